// ### design/cer_pkg.sv
package cer_pkg;
   // ------------------------------------------------------------
   // command opcodes
   // ------------------------------------------------------------
   localparam logic [7:0] CER_CMD_WR_ENMODE   = 8'h4A;
   localparam logic [7:0] CER_CMD_RD_ENMODE   = 8'h4B;
   localparam logic [7:0] CER_CMD_RT_KEEP     = 8'h4D;
   localparam logic [7:0] CER_CMD_RT_CLEAR    = 8'h4F;
   localparam logic [7:0] CER_CMD_WR_SLOTS    = 8'h44;
   localparam logic [7:0] CER_CMD_RD_SLOTS    = 8'h45;
   localparam logic [7:0] CER_RT_CMD_MASK     = 8'hFD;
   localparam int         CER_RT_CLEAR_BIT    = 1;
   // ------------------------------------------------------------
   // channel enable and mode layout
   // ------------------------------------------------------------
   localparam logic [7:0] CER_ENMODE_RESET    = 8'h0F;
   localparam int         CER_RBE_BIT         = 6;
   localparam int         CER_DRIVE_BIT       = 5;
   localparam int         CER_LPM_BIT         = 4;
   localparam int         CER_NUM_CHAN        = 4;
   localparam logic [3:0] CER_NO_CHAN         = 4'h0;

   typedef enum logic [0:0] {
      CER_IDLE,
      CER_WR_DATA
   } cer_phase_type;

   typedef struct packed {
      cer_phase_type phase;
      logic [7:0]    enmode;
      logic          rd_valid;
      logic [7:0]    rd_byte;
      logic          irq_clear;
      logic          refused;
      logic          low_power;
   } cer_state_type;
endpackage

// ### design/cer_rt_if.sv
`timescale 1ns/1ns
`default_nettype none
interface cer_rt_if;
   logic [3:0] debounced;
   logic [3:0] second;
   logic [7:0] rt_byte;
   modport packer (input debounced, input second, output rt_byte);
   modport user   (output debounced, output second, input rt_byte);
endinterface
`default_nettype wire

// ### design/cer_rt_pack.sv
`timescale 1ns/1ns
`default_nettype none
module cer_rt_pack
   import cer_pkg::*;
(
   cer_rt_if.packer rt   // line input bits in, packed byte out
);
   // ------------------------------------------------------------
   // interleave channel bits
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < CER_NUM_CHAN; g++)
      begin : g_chan
         assign rt.rt_byte[2*g]   = rt.debounced[g];
         assign rt.rt_byte[2*g+1] = rt.second[g];
      end
   endgenerate
endmodule
`default_nettype wire

// ### design/cer_regs.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - 4A writes, 4B reads enable/mode; one data byte follows.
// - robbed-bit handling active only when bit 6 set and mu-law selected.
// - enable bits 0..3 gate channel-specific commands per channel.
// - 4D reads real-time byte keeping interrupt; 4F also clears it.
// - both real-time opcodes return the same byte.
// - debounced bits sit in even positions, channel 1 at bit 0.
// - second bits sit in odd positions, channel 1 at bit 1.
// - channel 2 enable gates like the others.
// - real-time read works whatever the enable bits are.
// - slot/edge commands refused while no channel is enabled.
// - standby channel counts as inactive.
module cer_regs
   import cer_pkg::*;
#(
   parameter int NUM_CHAN = CER_NUM_CHAN
)
(
   input  wire logic       i_clk,                  // 100 MHz clock
   input  wire logic       i_rst,                  // sync reset, high
   input  wire logic       i_byte_valid,           // host byte strobe
   input  wire logic [7:0] i_byte,                 // host command or data byte
   input  wire logic [3:0] i_debounced_in,         // debounced first bits
   input  wire logic [3:0] i_second_in,            // second or muxed bits
   input  wire logic [3:0] i_channel_active_flag,  // per channel active
   input  wire logic       i_mulaw_select,         // mu-law companding on
   output logic            o_rd_valid,             // read byte strobe
   output logic [7:0]      o_rd_byte,              // read byte
   output logic            o_rt_irq_clear,         // clear rt interrupt
   output logic [3:0]      o_chan_cmd_accept,      // per channel accept
   output logic            o_shared_slot_allowed,  // slot/edge access ok
   output logic            o_shared_refused,       // slot cmd refused
   output logic            o_robbed_bit_active,    // robbed-bit on rx path
   output logic            o_analog_output_drive_select, // drive config
   output logic            o_low_power             // reduced-power state
);
   if (NUM_CHAN != CER_NUM_CHAN)
   begin : g_bad_chan
      $error("cer_regs serves exactly four channels");
   end

   cer_state_type state_reg;
   cer_state_type state_next;
   cer_rt_if      rt ();

   assign rt.debounced = i_debounced_in;
   assign rt.second    = i_second_in;

   cer_rt_pack u_pack (
      .rt (rt.packer)
   );

   // ------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------
   logic cmd_ok;
   logic is_rt;
   logic is_slots;
   logic clr_cmd;

   assign cmd_ok   = i_byte_valid && (state_reg.phase == CER_IDLE);
   assign is_rt    = (i_byte & CER_RT_CMD_MASK) == CER_CMD_RT_KEEP;
   assign is_slots = (i_byte == CER_CMD_WR_SLOTS) || (i_byte == CER_CMD_RD_SLOTS);
   assign clr_cmd  = cmd_ok && (i_byte == CER_CMD_RT_CLEAR);

   always_comb
   begin
      state_next           = state_reg;
      state_next.rd_valid  = 1'b0;
      state_next.irq_clear = 1'b0;
      state_next.refused   = 1'b0;
      unique case (state_reg.phase)
         CER_IDLE:
         begin
            if (cmd_ok && i_byte == CER_CMD_WR_ENMODE)
            begin
               state_next.phase = CER_WR_DATA;
            end
            else if (cmd_ok && i_byte == CER_CMD_RD_ENMODE)
            begin
               state_next.rd_valid = 1'b1;
               state_next.rd_byte  = state_reg.enmode;
            end
            else if (cmd_ok && is_rt)
            begin
               state_next.rd_valid  = 1'b1;
               state_next.rd_byte   = rt.rt_byte;
               state_next.irq_clear = i_byte[CER_RT_CLEAR_BIT];
            end
            else if (cmd_ok && is_slots)
            begin
               state_next.refused = state_reg.enmode[3:0] == CER_NO_CHAN;
            end
         end
         CER_WR_DATA:
         begin
            if (i_byte_valid)
            begin
               state_next.enmode = i_byte;
               state_next.phase  = CER_IDLE;
            end
         end
      endcase
      // reduced power only while all channels in standby
      state_next.low_power = state_next.enmode[CER_LPM_BIT]
                             && (i_channel_active_flag == CER_NO_CHAN);
      if (i_rst)
      begin
         state_next           = '0;
         state_next.phase     = CER_IDLE;
         state_next.enmode    = CER_ENMODE_RESET;
      end
   end

   always_ff @(posedge i_clk)
   begin
      state_reg <= state_next;
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign o_rd_valid             = state_reg.rd_valid;
   assign o_rd_byte              = state_reg.rd_byte;
   assign o_rt_irq_clear         = state_reg.irq_clear;
   assign o_chan_cmd_accept      = state_reg.enmode[3:0];
   assign o_shared_slot_allowed  = state_reg.enmode[3:0] != CER_NO_CHAN;
   assign o_shared_refused       = state_reg.refused;
   assign o_robbed_bit_active    = state_reg.enmode[CER_RBE_BIT] && i_mulaw_select;
   assign o_analog_output_drive_select = state_reg.enmode[CER_DRIVE_BIT];
   assign o_low_power            = state_reg.low_power;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence s_wr_cmd;
      cmd_ok && i_byte == CER_CMD_WR_ENMODE ##1 i_byte_valid;
   endsequence

   property p_write_stores;
      s_wr_cmd |=> state_reg.enmode == $past(i_byte);
   endproperty
   a_write_stores: assert property (p_write_stores) else $error("write not stored");

   property p_read_enmode;
      cmd_ok && i_byte == CER_CMD_RD_ENMODE |=> o_rd_valid && o_rd_byte == state_reg.enmode;
   endproperty
   a_read_enmode: assert property (p_read_enmode) else $error("enmode readback wrong");

   property p_rt_clear;
      // a back-to-back clear read may legally keep the pulse up
      clr_cmd |=> o_rd_valid && o_rt_irq_clear ##1 (!o_rt_irq_clear || $past(clr_cmd));
   endproperty
   a_rt_clear: assert property (p_rt_clear) else $error("clear read misbehaves");

   property p_rt_keep;
      cmd_ok && i_byte == CER_CMD_RT_KEEP |=> o_rd_valid && !o_rt_irq_clear;
   endproperty
   a_rt_keep: assert property (p_rt_keep) else $error("keep read cleared irq");

   property p_rt_bits;
      cmd_ok && is_rt |=> o_rd_byte[0] == $past(i_debounced_in[0])
                          && o_rd_byte[7] == $past(i_second_in[3])
                          && o_rd_byte[6] == $past(i_debounced_in[3]);
   endproperty
   a_rt_bits: assert property (p_rt_bits) else $error("rt byte misplaced");

   property p_accept_follows;
      s_wr_cmd |=> o_chan_cmd_accept == $past(i_byte[3:0]);
   endproperty
   a_accept_follows: assert property (p_accept_follows) else $error("accept mismatch");

   property p_reset_value;
      @(posedge i_clk) disable iff (1'b0)
      i_rst |=> o_chan_cmd_accept == 4'hF && !o_low_power && !o_robbed_bit_active;
   endproperty
   a_reset_value: assert property (p_reset_value) else $error("bad reset value");

   property p_rbe_mulaw;
      !i_mulaw_select |-> !o_robbed_bit_active;
   endproperty
   a_rbe_mulaw: assert property (p_rbe_mulaw) else $error("robbed-bit without mu-law");

   property p_lp_exit;
      (i_channel_active_flag != CER_NO_CHAN) |=> !o_low_power;
   endproperty
   a_lp_exit: assert property (p_lp_exit) else $error("low power while active");

   property p_slot_refuse;
      cmd_ok && is_slots && state_reg.enmode[3:0] == CER_NO_CHAN |=> o_shared_refused;
   endproperty
   a_slot_refuse: assert property (p_slot_refuse) else $error("slot cmd not refused");

   property p_rt_full;
      cmd_ok && is_rt |=> o_rd_byte == {$past(i_second_in[3]), $past(i_debounced_in[3]),
                                        $past(i_second_in[2]), $past(i_debounced_in[2]),
                                        $past(i_second_in[1]), $past(i_debounced_in[1]),
                                        $past(i_second_in[0]), $past(i_debounced_in[0])};
   endproperty
   a_rt_full: assert property (p_rt_full) else $error("rt byte order wrong");

   property p_lp_enter;
      state_reg.phase == CER_IDLE && state_reg.enmode[CER_LPM_BIT]
         && i_channel_active_flag == CER_NO_CHAN |=> o_low_power;
   endproperty
   a_lp_enter: assert property (p_lp_enter) else $error("low power not entered");

   property p_lp_clear;
      s_wr_cmd ##0 !i_byte[CER_LPM_BIT] |=> !o_low_power;
   endproperty
   a_lp_clear: assert property (p_lp_clear) else $error("low power after field clear");

   property p_drive_follows;
      s_wr_cmd |=> o_analog_output_drive_select == $past(i_byte[CER_DRIVE_BIT]);
   endproperty
   a_drive_follows: assert property (p_drive_follows) else $error("drive select mismatch");
endmodule
`default_nettype wire

// ### sim/cer_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module cer_host_model
   import cer_pkg::*;
(
   input  wire logic       i_clk,        // host port clock
   output var  logic       o_byte_valid, // byte strobe
   output var  logic [7:0] o_byte        // command or data byte
);
   initial
   begin
      o_byte_valid = 1'b0;
      o_byte       = 8'h00;
   end
   // one byte per strobe, moved on the falling edge
   task automatic put(input logic [7:0] b);
      @(negedge i_clk);
      o_byte_valid = 1'b1;
      o_byte       = b;
      @(negedge i_clk);
      o_byte_valid = 1'b0;
      o_byte       = ~b;
   endtask
   // command then exactly one data byte, reserved bit kept clear
   task automatic wr_enmode(input logic [7:0] v);
      put(CER_CMD_WR_ENMODE);
      put({1'b0, v[6:0]});
   endtask
endmodule
`default_nettype wire

// ### sim/tb_cer_regs.sv
`timescale 1ns/1ns
`default_nettype none
module tb_cer_regs;
   import cer_pkg::*;
   logic       i_clk = 1'b0;
   logic       i_rst = 1'b1;
   logic       host_valid;
   logic [7:0] host_byte;
   logic [3:0] deb = 4'h0;
   logic [3:0] sec = 4'h0;
   logic [3:0] act = 4'hF;
   logic       mulaw = 1'b1;
   logic       rd_valid, irq_clr, allowed, refused, robbed, drive, low_power;
   logic [7:0] rd_byte;
   logic [3:0] accept;
   logic [7:0] pats [4] = '{8'h1E, 8'hA5, 8'hF0, 8'h0F};
   int         bad_count = 0;
   int         compares = 0;
   int         cycles = 0;

   always #5 i_clk = ~i_clk;

   cer_host_model i_cer_host_model (.i_clk(i_clk), .o_byte_valid(host_valid), .o_byte(host_byte));

   cer_regs i_cer_regs (
      .i_clk(i_clk), .i_rst(i_rst), .i_byte_valid(host_valid), .i_byte(host_byte),
      .i_debounced_in(deb), .i_second_in(sec), .i_channel_active_flag(act),
      .i_mulaw_select(mulaw), .o_rd_valid(rd_valid), .o_rd_byte(rd_byte),
      .o_rt_irq_clear(irq_clr), .o_chan_cmd_accept(accept),
      .o_shared_slot_allowed(allowed), .o_shared_refused(refused),
      .o_robbed_bit_active(robbed), .o_analog_output_drive_select(drive),
      .o_low_power(low_power));

   // ------------------------------------------------------------
   // checking and closing
   // ------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      compares++;
      if (got !== exp)
      begin
         bad_count++;
         $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic results;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   function automatic logic [7:0] pack(input logic [3:0] a, input logic [3:0] b);
      logic [7:0] r;
      for (int k = 0; k < 4; k++)
      begin
         r[2*k]   = a[k];
         r[2*k+1] = b[k];
      end
      return r;
   endfunction

   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         bad_count++;
         results();
      end
   end

   // ------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (5) @(negedge i_clk);
      i_rst = 1'b0;
      chk(accept, 8'h0F, "reset accept");
      chk(robbed, 8'h00, "reset robbed");
      chk(drive, 8'h00, "reset drive");
      i_cer_host_model.put(CER_CMD_RD_ENMODE);
      chk(rd_valid, 8'h01, "reset read valid");
      chk(rd_byte, 8'h0F, "reset value");
      i_cer_host_model.wr_enmode(8'h71);
      chk(accept, 8'h01, "accept ch1");
      chk(drive, 8'h01, "drive set");
      chk(robbed, 8'h01, "robbed mulaw");
      i_cer_host_model.put(CER_CMD_RD_ENMODE);
      chk(rd_byte, 8'h71, "readback");
      mulaw = 1'b0;
      #1 chk(robbed, 8'h00, "robbed alaw");
      act = 4'h0;
      repeat (2) @(negedge i_clk);
      chk(low_power, 8'h01, "low power on");
      act = 4'h4;
      repeat (2) @(negedge i_clk);
      chk(low_power, 8'h00, "one active");
      act = 4'h0;
      i_cer_host_model.wr_enmode(8'h61);
      @(negedge i_clk);
      chk(low_power, 8'h00, "field clear");
      i_cer_host_model.wr_enmode(8'h02);
      chk(accept, 8'h02, "accept ch2");
      i_cer_host_model.put(CER_CMD_WR_SLOTS);
      chk(refused, 8'h00, "slot allowed");
      i_cer_host_model.wr_enmode(8'h00);
      chk(allowed, 8'h00, "none enabled");
      i_cer_host_model.put(CER_CMD_RD_SLOTS);
      chk(refused, 8'h01, "slot refused");
      foreach (pats[i])
      begin
         {deb, sec} = pats[i];
         i_cer_host_model.put(CER_CMD_RT_KEEP);
         chk(rd_valid, 8'h01, "rt keep valid");
         chk(rd_byte, pack(deb, sec), "rt keep byte");
         chk(irq_clr, 8'h00, "rt keep clear");
         i_cer_host_model.put(CER_CMD_RT_CLEAR);
         chk(rd_valid, 8'h01, "rt clear valid");
         chk(rd_byte, pack(deb, sec), "rt clear byte");
         chk(irq_clr, 8'h01, "rt clear pulse");
         @(negedge i_clk);
         chk(irq_clr, 8'h00, "clear one cycle");
      end
      // reset again in mid-run with no channel enabled
      i_rst = 1'b1;
      repeat (2) @(negedge i_clk);
      i_rst = 1'b0;
      chk(accept, 8'h0F, "mid-run reset accept");
      chk(allowed, 8'h01, "mid-run reset allowed");
      i_cer_host_model.put(CER_CMD_RD_ENMODE);
      chk(rd_byte, 8'h0F, "mid-run reset value");
      results();
   end
endmodule
`default_nettype wire
